// ===== common/spba_defines.svh
// Constants for the secondary bus arbiter and control block.
// Assumes inclusion by bare name from package and design files.
`ifndef SPBA_DEFINES_SVH
`define SPBA_DEFINES_SVH
`define SPBA_NUM_MASTERS      6
`define SPBA_LOCK_EN_BIT      12
`define SPBA_GEN_CTRL_RESET   16'h0000
`define SPBA_CORE_CLK_MHZ     100
`define SPBA_RST_TIME_US      100
`define SPBA_RST_CYCLES       (`SPBA_RST_TIME_US * `SPBA_CORE_CLK_MHZ)
`define SPBA_IDLE_WAIT_CYCLES 2
// Clock output half periods, in 100 MHz core cycles, for the 66, 50, 33, 25 MHz selections
`define SPBA_DIV_66           8'h02
`define SPBA_DIV_50           8'h02
`define SPBA_DIV_33           8'h03
`define SPBA_DIV_25           8'h04
`endif

// ===== common/spba_pkg.sv
// Types shared by the secondary bus arbiter and control block.
// Assumes spba_defines.svh is on the include path.
`include "spba_defines.svh"
package spba_pkg;
	// Bus speed selections
	typedef enum logic [1:0] {
		SPBA_SPD_25 = 2'b00,
		SPBA_SPD_33 = 2'b01,
		SPBA_SPD_50 = 2'b10,
		SPBA_SPD_66 = 2'b11
	} spba_speed_e;
	// Arbiter states
	typedef enum logic [1:0] {
		SPBA_ARB_IDLE  = 2'b00,
		SPBA_ARB_GRANT = 2'b01,
		SPBA_ARB_BUSY  = 2'b10
	} spba_arb_e;
endpackage

// ===== hdl/spba_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes inputs asynchronous to core_clk_i.
module spba_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	// Data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;   // First stage, read only by q_o

	// Two stage capture
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= INIT;
			q_o    <= INIT;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

// ===== hdl/spba_top.sv
// Secondary PCI bus arbiter, lock enable, clock rate, reset and side inputs.
// Assumes PCI pins arrive asynchronously; pullups resolve open lines outside.
`include "spba_defines.svh"
//
// Contract
// - Internal mode drives six grant outputs.
// - Internal mode samples six request inputs.
// - External mode: grant zero is own request.
// - External mode: request zero is own grant.
// - Accept interrupt lines A to D.
// - Lock pin works only when lock enabled.
// - 66 low: 33 MHz, or 25 when select low.
// - 66 high: 66 MHz, or 50 when select low.
// - Power event input detects wake requests.
// - Drive secondary bus reset output.
module spba_top #(
	parameter int NUM_MASTERS = `SPBA_NUM_MASTERS,
	parameter int RST_CYCLES  = `SPBA_RST_CYCLES
) (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     resetn_i,
	// Configuration
	input  wire logic                     ext_arb_en_i,
	input  wire logic [15:0]              gen_ctrl_i,
	input  wire logic                     bus_reset_req_i,
	input  wire logic                     own_req_i,
	// Speed straps
	input  wire logic                     m66_enable_i,
	input  wire logic                     pci_clock_rate_select_i,
	// Arbitration pins, active low
	input  wire logic [NUM_MASTERS-1:0]   req_n_i,
	output logic      [NUM_MASTERS-1:0]   gnt_n_o,
	// Bus activity pins, active low
	input  wire logic                     frame_n_i,
	input  wire logic                     irdy_n_i,
	// Lock pin as three signals, plus own lock request
	input  wire logic                     lock_n_i,
	output logic                          lock_n_o,
	output logic                          lock_n_oe_o,
	input  wire logic                     own_lock_i,
	// Interrupt and power event pins, active low
	input  wire logic [3:0]               int_n_i,
	input  wire logic                     pme_n_i,
	// Status outputs
	output logic                          own_gnt_o,
	output logic [3:0]                    int_level_o,
	output logic                          pme_event_o,
	output logic                          lock_seen_o,
	output spba_pkg::spba_speed_e         speed_o,
	output logic                          clk_out_o,
	output logic                          secondary_bus_reset_out_n_o
);
	import spba_pkg::*;

	// Refuse parameter values the logic cannot serve
	if (NUM_MASTERS < 1 || NUM_MASTERS > 6) begin : g_bad_masters
		$error("NUM_MASTERS out of range");
	end
	if (RST_CYCLES < 1) begin : g_bad_rst
		$error("RST_CYCLES must be positive");
	end

	localparam int CW = $clog2(RST_CYCLES + 1);
	localparam int SW = NUM_MASTERS + 4 + 6;

	// Synchronised pins
	logic [SW-1:0]          pins_s;
	logic [NUM_MASTERS-1:0] req_s;
	logic [3:0]             int_s;
	logic                   frame_s;
	logic                   irdy_s;
	logic                   lock_s;
	logic                   pme_s;
	logic                   m66_s;
	logic                   sel_s;

	spba_sync #(.WIDTH(SW), .INIT({SW{1'b1}})) u_sync (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.d_i        ({req_n_i, int_n_i, frame_n_i, irdy_n_i, lock_n_i, pme_n_i,
		              m66_enable_i, pci_clock_rate_select_i}),
		.q_o        (pins_s)
	);

	// Split synchronised vector
	assign req_s   = ~pins_s[SW-1 -: NUM_MASTERS];
	assign int_s   = ~pins_s[9:6];
	assign frame_s = ~pins_s[5];
	assign irdy_s  = ~pins_s[4];
	assign lock_s  = ~pins_s[3];
	assign pme_s   = ~pins_s[2];
	assign m66_s   = pins_s[1];
	assign sel_s   = pins_s[0];

	// Bus idle when neither frame nor initiator ready
	wire bus_idle = !frame_s && !irdy_s;
	wire lock_en  = gen_ctrl_i[`SPBA_LOCK_EN_BIT];

	// Arbiter state
	spba_arb_e              arb_r, arb_nxt;
	logic [NUM_MASTERS-1:0] gnt_r, gnt_nxt;
	logic [2:0]             last_r, last_nxt;
	logic [2:0]             pick;
	logic                   pick_ok;

	// Round robin pick after last owner
	always_comb begin
		logic [2:0] idx;
		pick    = last_r;
		pick_ok = 1'b0;
		idx     = 3'h0;
		for (int k = NUM_MASTERS; k >= 1; k--) begin
			idx = 3'((int'(last_r) + k) % NUM_MASTERS);
			if (req_s[idx]) begin
				pick    = idx;
				pick_ok = 1'b1;
			end
		end
	end

	// Arbiter next state, one-hot grants only
	always_comb begin
		arb_nxt  = arb_r;
		gnt_nxt  = gnt_r;
		last_nxt = last_r;
		unique case (arb_r)
			SPBA_ARB_IDLE: begin
				if (!ext_arb_en_i && pick_ok && bus_idle) begin
					gnt_nxt  = NUM_MASTERS'(1) << pick;
					last_nxt = pick;
					arb_nxt  = SPBA_ARB_GRANT;
				end
			end
			SPBA_ARB_GRANT: begin
				// Owner started a frame, or dropped its request before starting
				if (frame_s) begin
					arb_nxt = SPBA_ARB_BUSY;
				end else if (!req_s[last_r] || ext_arb_en_i) begin
					gnt_nxt = '0;
					arb_nxt = SPBA_ARB_IDLE;
				end
			end
			SPBA_ARB_BUSY: begin
				// Remove grant when the transaction starts, rearbitrate on idle
				gnt_nxt = '0;
				if (bus_idle) begin
					arb_nxt = SPBA_ARB_IDLE;
				end
			end
			default: begin
				gnt_nxt = '0;
				arb_nxt = SPBA_ARB_IDLE;
			end
		endcase
	end

	// Arbiter registers
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			arb_r  <= SPBA_ARB_IDLE;
			gnt_r  <= '0;
			last_r <= 3'h0;
		end else begin
			arb_r  <= arb_nxt;
			gnt_r  <= gnt_nxt;
			last_r <= last_nxt;
		end
	end

	// Grant pins: internal grants, or own request on grant zero
	logic [NUM_MASTERS-1:0] gnt_pin_nxt;
	assign gnt_pin_nxt = ext_arb_en_i ? {{(NUM_MASTERS-1){1'b1}}, ~own_req_i}
	                                  : ~gnt_r;

	// Speed decode from straps
	spba_speed_e speed_nxt;
	assign speed_nxt = m66_s ? (sel_s ? SPBA_SPD_66 : SPBA_SPD_50)
	                         : (sel_s ? SPBA_SPD_33 : SPBA_SPD_25);

	// Clock output divider from core clock
	logic [7:0] div_max;
	logic [7:0] div_cnt_r;
	assign div_max = (speed_o == SPBA_SPD_66) ? `SPBA_DIV_66 :
	                 (speed_o == SPBA_SPD_50) ? `SPBA_DIV_50 :
	                 (speed_o == SPBA_SPD_33) ? `SPBA_DIV_33 : `SPBA_DIV_25;
	wire div_tick = (div_cnt_r >= div_max - 8'h01);

	// Secondary reset counter
	logic [CW-1:0] rst_cnt_r;
	wire           rst_done = (rst_cnt_r == CW'(RST_CYCLES));

	// Power event edge
	logic pme_d_r;

	// Output registers
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gnt_n_o                     <= {NUM_MASTERS{1'b1}};
			own_gnt_o                   <= 1'b0;
			int_level_o                 <= 4'h0;
			pme_event_o                 <= 1'b0;
			pme_d_r                     <= 1'b0;
			lock_n_o                    <= 1'b1;
			lock_n_oe_o                 <= 1'b0;
			lock_seen_o                 <= 1'b0;
			speed_o                     <= SPBA_SPD_25;
			div_cnt_r                   <= 8'h00;
			clk_out_o                   <= 1'b0;
			rst_cnt_r                   <= '0;
			secondary_bus_reset_out_n_o <= 1'b0;
		end else begin
			gnt_n_o     <= gnt_pin_nxt;
			own_gnt_o   <= ext_arb_en_i && req_s[0];
			int_level_o <= int_s;
			pme_d_r     <= pme_s;
			pme_event_o <= pme_s && !pme_d_r;
			lock_n_o    <= ~(lock_en && own_lock_i);
			lock_n_oe_o <= lock_en && own_lock_i;
			lock_seen_o <= lock_en && lock_s;
			speed_o     <= speed_nxt;
			div_cnt_r   <= div_tick ? 8'h00 : div_cnt_r + 8'h01;
			if (div_tick) begin
				clk_out_o <= ~clk_out_o;
			end
			// Hold reset for the timed span, restart on request
			if (bus_reset_req_i) begin
				rst_cnt_r <= '0;
			end else if (!rst_done) begin
				rst_cnt_r <= rst_cnt_r + CW'(1);
			end
			secondary_bus_reset_out_n_o <= rst_done && !bus_reset_req_i;
		end
	end
endmodule

// ===== verif/spba_master_model.sv
// Secondary bus masters and an optional external arbiter.
// Assumes pins are released high by pullups when idle.
module spba_master_model (
	// Clock and mode
	input  wire logic       clk_i,
	input  wire logic       ext_i,
	// Wishes of the masters, grants seen
	input  wire logic [5:0] want_i,
	input  wire logic [5:0] gnt_n_i,
	// Bus pins
	output logic      [5:0] req_n_o,
	output logic            frame_n_o,
	output logic            irdy_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_r = 3'h0; // Remaining cycles of a transfer
	// Granted master starts a short transfer on an idle bus
	always_ff @(negedge clk_i) begin
		if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
		else if (!ext_i && gnt_n_i != 6'h3F)
			cnt_r <= 3'h4;
	end
	assign frame_n_o = !(cnt_r > 3'h1);
	assign irdy_n_o  = (cnt_r == 3'h0);
	// External arbiter grants the bridge at once
	assign req_n_o = ext_i ? {~want_i[5:1], gnt_n_i[0]} : ~want_i;
endmodule

// ===== verif/spba_monitor.sv
// Checker for the secondary bus arbiter and control block.
// Assumes binding onto spba_top; sees only its ports.
module spba_monitor
	import spba_pkg::*;
#(
	parameter int NUM_MASTERS = 6
) (
	// Clock, reset, controls
	input wire logic                   core_clk_i,
	input wire logic                   resetn_i,
	input wire logic                   ext_arb_en_i,
	input wire logic [15:0]            gen_ctrl_i,
	input wire logic                   bus_reset_req_i,
	input wire logic                   own_req_i,
	input wire logic                   m66_enable_i,
	input wire logic                   pci_clock_rate_select_i,
	// Pins and status
	input wire logic [NUM_MASTERS-1:0] req_n_i,
	input wire logic [NUM_MASTERS-1:0] gnt_n_o,
	input wire logic [3:0]             int_n_i,
	input wire logic                   own_gnt_o,
	input wire logic [3:0]             int_level_o,
	input wire logic                   pme_event_o,
	input wire logic                   lock_seen_o,
	input wire logic                   lock_n_oe_o,
	input wire spba_speed_e            speed_o,
	input wire logic                   secondary_bus_reset_out_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	one_grant_a: assert property ($onehot0(~gnt_n_o)) else $error("two grants low");
	ext_req_a: assert property ((ext_arb_en_i && own_req_i)[*4] |-> !gnt_n_o[0])
		else $error("own request missing");
	ext_quiet_a: assert property (ext_arb_en_i[*4] |-> &gnt_n_o[NUM_MASTERS-1:1])
		else $error("grant in external mode");
	own_gnt_a: assert property ((ext_arb_en_i && !req_n_i[0])[*5] |-> own_gnt_o)
		else $error("own grant missing");
	lock_off_a: assert property ((!gen_ctrl_i[12])[*3] |-> !lock_n_oe_o && !lock_seen_o)
		else $error("lock active while disabled");
	speed_hi_a: assert property ((m66_enable_i && pci_clock_rate_select_i)[*5] |-> speed_o == SPBA_SPD_66)
		else $error("speed not 66");
	speed_lo_a: assert property ((!m66_enable_i && !pci_clock_rate_select_i)[*5] |-> speed_o == SPBA_SPD_25)
		else $error("speed not 25");
	int_pass_a: assert property ($stable(int_n_i)[*5] |-> int_level_o == ~int_n_i)
		else $error("interrupt level wrong");
	pme_pulse_a: assert property (pme_event_o |=> !pme_event_o) else $error("power event too long");
	rst_req_a: assert property (bus_reset_req_i[*3] |-> !secondary_bus_reset_out_n_o)
		else $error("bus reset not held");
	// Main scenarios reached
	cover property (!ext_arb_en_i && !gnt_n_o[2]);
	cover property (own_gnt_o);
	cover property (pme_event_o);
endmodule
bind spba_top spba_monitor #(.NUM_MASTERS(NUM_MASTERS)) i_spba_monitor (.core_clk_i(core_clk_i),
	.resetn_i(resetn_i), .ext_arb_en_i(ext_arb_en_i), .gen_ctrl_i(gen_ctrl_i), .bus_reset_req_i(bus_reset_req_i),
	.own_req_i(own_req_i), .m66_enable_i(m66_enable_i), .pci_clock_rate_select_i(pci_clock_rate_select_i),
	.req_n_i(req_n_i), .gnt_n_o(gnt_n_o), .int_n_i(int_n_i), .own_gnt_o(own_gnt_o), .int_level_o(int_level_o),
	.pme_event_o(pme_event_o), .lock_seen_o(lock_seen_o), .lock_n_oe_o(lock_n_oe_o), .speed_o(speed_o),
	.secondary_bus_reset_out_n_o(secondary_bus_reset_out_n_o));

// ===== verif/spba_top_tb.sv
// Self-checking bench for the secondary bus arbiter and control block.
// Assumes the master model file and the checker are compiled before.
`include "spba_defines.svh"
module spba_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spba_pkg::*;
	localparam int RST = 16;
	// Clock output half periods, in speed code order 25, 33, 50, 66
	localparam logic [7:0] DIVS [4] = '{`SPBA_DIV_25, `SPBA_DIV_33, `SPBA_DIV_50, `SPBA_DIV_66};
	// Stimulus and observed signals
	logic core_clk = 0, resetn = 0, ext = 0, brr = 0, oreq = 0, m66 = 0, sel = 0, olock = 0, lock_drv = 1, pme_n = 1;
	logic [15:0] gctl = 16'h0000;
	logic [5:0] want = 6'h00, req_n, gnt_n, seen;
	logic [3:0] int_n = 4'hF, lvl;
	logic frame_n, irdy_n, lock_o, lock_oe, own_gnt, pme_ev, lock_seen, sro_n, clk_out, g;
	spba_speed_e spd;
	wire lock_w = lock_oe ? lock_o : lock_drv; // Pullup when nobody drives
	int error_cnt = 0, n_tests = 0, k, j;
	always #5 core_clk = ~core_clk;
	spba_top #(.RST_CYCLES(RST)) i_spba_top (.core_clk_i(core_clk), .resetn_i(resetn), .ext_arb_en_i(ext),
		.gen_ctrl_i(gctl), .bus_reset_req_i(brr), .own_req_i(oreq), .m66_enable_i(m66),
		.pci_clock_rate_select_i(sel), .req_n_i(req_n), .gnt_n_o(gnt_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
		.lock_n_i(lock_w), .lock_n_o(lock_o), .lock_n_oe_o(lock_oe), .own_lock_i(olock), .int_n_i(int_n),
		.pme_n_i(pme_n), .own_gnt_o(own_gnt), .int_level_o(lvl), .pme_event_o(pme_ev), .lock_seen_o(lock_seen),
		.speed_o(spd), .clk_out_o(clk_out), .secondary_bus_reset_out_n_o(sro_n));
	spba_master_model i_spba_master_model (.clk_i(core_clk), .ext_i(ext), .want_i(want), .gnt_n_i(gnt_n),
		.req_n_o(req_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n));
	// Compare and report
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Test sequence
	initial begin
		cyc(8);
		resetn = 1;
		chk("reset_out", 8'h00, sro_n);
		cyc(RST + 6);
		chk("reset_rel", 8'h01, sro_n);
		want = 6'h04;
		for (k = 0; k < 20 && gnt_n[2]; k++) cyc(1);
		chk("grant", 8'h3B, gnt_n);
		want = 6'h00;
		cyc(12);
		$display("grant test done");
		seen = 6'h00;
		want = 6'h21;
		repeat (80) begin
			cyc(1);
			seen |= ~gnt_n;
		end
		chk("rotation", 8'h21, seen);
		want = 6'h00;
		cyc(12);
		ext = 1;
		oreq = 1;
		want = 6'h3E;
		cyc(8);
		chk("ext_req", 8'h3E, gnt_n);
		chk("own_gnt", 8'h01, own_gnt);
		oreq = 0;
		cyc(8);
		chk("ext_idle", 8'h3F, gnt_n);
		chk("own_gnt_off", 8'h00, own_gnt);
		ext = 0;
		want = 6'h00;
		cyc(12);
		$display("arbiter mode test done");
		gctl = 16'h1000;
		olock = 1;
		cyc(6);
		chk("lock_drive", 8'h02, {lock_oe, lock_w});
		chk("lock_seen", 8'h01, lock_seen);
		lock_drv = 0;
		gctl = 16'h0000;
		cyc(6);
		chk("lock_off", 8'h00, {lock_oe, lock_seen});
		olock = 0;
		lock_drv = 1;
		for (k = 0; k < 4; k++) begin
			{m66, sel} = k[1:0];
			cyc(6);
			chk("speed", k[7:0], spd);
			// Align to a toggle, then count cycles to the next one
			g = clk_out;
			for (j = 0; j < 20 && clk_out == g; j++) cyc(1);
			g = clk_out;
			for (j = 0; j < 20 && clk_out == g; j++) cyc(1);
			chk("clk_half", DIVS[k], j[7:0]);
		end
		int_n = 4'hA;
		cyc(6);
		chk("int_level", 8'h05, lvl);
		int_n = 4'hF;
		k = 0;
		pme_n = 0;
		repeat (10) begin
			cyc(1);
			k += pme_ev;
		end
		chk("pme_pulses", 8'h01, k[7:0]);
		pme_n = 1;
		$display("side input test done");
		brr = 1;
		cyc(5);
		chk("reset_req", 8'h00, sro_n);
		brr = 0;
		for (k = 0; k < 60 && !sro_n; k++) cyc(1);
		chk("reset_len", 8'h01, (k >= RST) && sro_n);
		$display("reset test done");
		wrap_up;
	end
	// Watchdog against a hang
	initial begin
		#50000;
		error_cnt++;
		wrap_up;
	end
endmodule
